// >>> hdl/load_store_access_unit.v
// Load/store access unit with AXI4-Lite register port
// Function
// (RULE_01) Object addressed by its lowest byte
// (RULE_02) Size code n moves n+1 bytes
// (RULE_03) Lanes from size code and low bits
// (RULE_04) Load element is register wide, aligned; cached narrow loads return the whole 64-bit entry
// (RULE_05) Uncached load reads only referenced bytes
// (RULE_06) Cached miss fills whole aligned block
// (RULE_07) Store changes only selected bytes
// (RULE_08) Unmapped direct; mapped via table, else exception
// (RULE_09) Prefetch never changes visible state
// (RULE_10) Sync orders selected loads and stores
// (RULE_11) Coprocessor writes loaded value to register
// (RULE_12) Coprocessor supplies low word for store
// (RULE_13) Function field passed unchanged to unit; code passes only the 8-bit arg, upper 17 bits zero
// (RULE_14) Contiguous lanes, big-endian from MSB end
`include "lsu_defines.vh"
module load_store_access_unit (
   input  wire        mclk,
   input  wire        reset,
   input  wire [7:0]  awaddr,
   input  wire        awvalid,
   output reg         awready,
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output reg         wready,
   output reg  [1:0]  bresp,
   output reg         bvalid,
   input  wire        bready,
   input  wire [7:0]  araddr,
   input  wire        arvalid,
   output reg         arready,
   output reg  [31:0] rdata,
   output reg  [1:0]  rresp,
   output reg         rvalid,
   input  wire        rready,
   output reg  [24:0] copFunction,
   output reg  [1:0]  copUnit,
   output reg         copStrobe,
   output reg  [7:0]  syncType,
   output reg         syncStrobe,
   output reg         irq
);
   // ----------------------------------------
   // Registers and memory
   // ----------------------------------------
   reg [2:0]  ctrl;
   reg [4:0]  status;
   reg [4:0]  mask;
   reg [31:0] virtualAddress;
   reg [63:0] storeData;
   reg [63:0] memoryElement;
   reg [31:0] physAddr;
   reg [7:0]  laneReg;
   reg [1:0]  cacheAttribute;
   reg [7:0]  memAddrSel;
   reg [63:0] mem [0:`MEM_WORDS-1];
   reg [63:0] cacheData [0:`MEM_WORDS-1];
   reg [`MEM_WORDS-1:0] cacheValid;
   reg [`MEM_WORDS-1:0] mapAllow;
   reg [7:0]  awAddrHold;
   reg        awHeld;
   reg [31:0] wDataHold;
   reg        wHeld;
   reg [3:0]  wStrbHold;
   reg [4:0]  setEvents;
   integer    k;

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   wire        cmdGo = awHeld && wHeld && !bvalid && wStrbHold != 4'h0
                       && awAddrHold == `REG_CMD;
   wire [2:0]  opCode = wDataHold[`CMD_OP_HI:`CMD_OP_LO];
   wire [2:0]  accessSizeCode = wDataHold[`CMD_SIZE_HI:`CMD_SIZE_LO];
   wire        cachedReq = wDataHold[`CMD_CACHED];
   wire        fetchOrDataSelect = wDataHold[`CMD_FETCH];
   wire        loadOrStoreSelect = (opCode == `OP_STORE);
   wire [7:0]  laneEnable;
   wire        misfit;
   wire        unmapped = virtualAddress[`UNMAPPED_BIT];
   wire [`MEM_AW-1:0] elemIdx = ctrl[`CTRL_WIDE64] ? virtualAddress[`MEM_AW+2:3]
                                                  : virtualAddress[`MEM_AW+1:2];
   wire        mapFault = ctrl[`CTRL_MAPEN] && !unmapped && !mapAllow[elemIdx];
   wire [63:0] elemOld = mem[elemIdx];
   reg  [63:0] mergedStore;
   reg  [63:0] uncachedLoad;

   // Misfit marks an access that crosses the element
   lane_select u_lane_select (
      .accessSizeCode (accessSizeCode),
      .lowAddr        (virtualAddress[2:0]),
      .bigEndian      (ctrl[`CTRL_BIGEND]),
      .wide64         (ctrl[`CTRL_WIDE64]),
      .laneEnable     (laneEnable),
      .misfit         (misfit)
   );

   // ----------------------------------------
   // Address translation
   // ----------------------------------------
   // Both spaces drop the region bit; mapped space only adds the permission check
   wire [31:0] translatedAddr = {1'b0, virtualAddress[`UNMAPPED_BIT-1:0]}; // RULE_08
   wire [1:0]  translatedAttr = {fetchOrDataSelect, cachedReq};

   // ----------------------------------------
   // Byte merge per lane
   // ----------------------------------------
   always @* begin
      for (k = 0; k < 8; k = k + 1) begin
         mergedStore[k*8 +: 8] = laneEnable[k] ? storeData[k*8 +: 8]
                                               : elemOld[k*8 +: 8]; // RULE_07
         uncachedLoad[k*8 +: 8] = laneEnable[k] ? elemOld[k*8 +: 8] : 8'h00; // RULE_05
      end
      // Narrow element: upper word never touched
      if (!ctrl[`CTRL_WIDE64]) begin
         mergedStore[63:32] = elemOld[63:32];
         uncachedLoad[63:32] = 32'h00000000; // RULE_04
      end
   end

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   always @(posedge mclk) begin
      if (reset) begin
         awready <= 1'b1;
         wready <= 1'b1;
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddrHold <= 8'h00;
         wDataHold <= 32'h00000000;
         wStrbHold <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            awAddrHold <= awaddr;
            awHeld <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            wDataHold <= wdata;
            // Strobes held too; the master may move them once taken
            wStrbHold <= wstrb;
            wHeld <= 1'b1;
            wready <= 1'b0;
         end
         if (awHeld && wHeld && !bvalid) begin
            bvalid <= 1'b1;
            case (awAddrHold)
               `REG_CTRL, `REG_STATUS, `REG_MASK, `REG_VIRTUAL_ADDRESS, `REG_WDATALO,
               `REG_WDATAHI, `REG_CMD, `REG_MEMADDR, `REG_MEMLO, `REG_MEMHI:
                  bresp <= `RESP_OKAY;
               default: bresp <= `RESP_SLVERR;
            endcase
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Register writes and command execution
   // ----------------------------------------
   wire doWrite = awHeld && wHeld && !bvalid;
   always @(posedge mclk) begin
      if (reset) begin
         ctrl <= 3'h0;
         mask <= 5'h00;
         virtualAddress <= 32'h00000000;
         storeData <= 64'h0;
         memoryElement <= 64'h0;
         physAddr <= 32'h00000000;
         laneReg <= 8'h00;
         cacheAttribute <= 2'h0;
         memAddrSel <= 8'h00;
         cacheValid <= {`MEM_WORDS{1'b0}};
         mapAllow <= {`MEM_WORDS{1'b0}};
         copFunction <= 25'h0;
         copUnit <= 2'h0;
         copStrobe <= 1'b0;
         syncType <= 8'h00;
         syncStrobe <= 1'b0;
         setEvents <= 5'h00;
      end else begin
         copStrobe <= 1'b0;
         syncStrobe <= 1'b0;
         setEvents <= 5'h00;
         if (doWrite && wStrbHold != 4'h0) begin
            case (awAddrHold)
               `REG_CTRL:    ctrl <= wDataHold[2:0];
               `REG_MASK:    mask <= wDataHold[4:0];
               `REG_VIRTUAL_ADDRESS:   virtualAddress <= wDataHold;
               `REG_WDATALO: storeData[31:0] <= wDataHold;
               `REG_WDATAHI: storeData[63:32] <= wDataHold;
               `REG_MEMADDR: memAddrSel <= wDataHold[7:0];
               // Cached copy follows back-door memory writes
               `REG_MEMLO: begin
                  mem[memAddrSel[`MEM_AW-1:0]][31:0] <= wDataHold;
                  cacheData[memAddrSel[`MEM_AW-1:0]][31:0] <= wDataHold;
               end
               `REG_MEMHI: begin
                  mem[memAddrSel[`MEM_AW-1:0]][63:32] <= wDataHold;
                  cacheData[memAddrSel[`MEM_AW-1:0]][63:32] <= wDataHold;
               end
               // Map table entries use bit 31 of the memory-address word
               default: ;
            endcase
            if (awAddrHold == `REG_MEMADDR) begin
               mapAllow[wDataHold[`MEM_AW-1:0]] <= wDataHold[31];
            end
         end
         if (cmdGo) begin
            case (opCode)
               `OP_LOAD, `OP_STORE: begin
                  if (mapFault || misfit) begin
                     setEvents[`ST_EXC] <= 1'b1; // RULE_08
                  end else begin
                     // Lanes follow real accesses only; prefetch stays invisible
                     laneReg <= laneEnable; // RULE_03
                     physAddr <= translatedAddr; // RULE_08
                     cacheAttribute <= translatedAttr; // RULE_08
                     setEvents[`ST_DONE] <= 1'b1;
                     if (loadOrStoreSelect) begin
                        mem[elemIdx] <= mergedStore; // RULE_07
                        cacheData[elemIdx] <= mergedStore;
                     end else if (cachedReq) begin
                        // Hit serves the cached copy
                        if (cacheValid[elemIdx]) begin
                           memoryElement <= cacheData[elemIdx]; // RULE_06
                        end else begin
                           memoryElement <= elemOld;
                        end
                        if (!cacheValid[elemIdx]) begin
                           // Fill aligned pair of elements as one block
                           cacheValid[{elemIdx[`MEM_AW-1:1], 1'b0}] <= 1'b1; // RULE_06
                           cacheValid[{elemIdx[`MEM_AW-1:1], 1'b1}] <= 1'b1; // RULE_06
                           cacheData[{elemIdx[`MEM_AW-1:1], 1'b0}] <=
                              mem[{elemIdx[`MEM_AW-1:1], 1'b0}];
                           cacheData[{elemIdx[`MEM_AW-1:1], 1'b1}] <=
                              mem[{elemIdx[`MEM_AW-1:1], 1'b1}];
                        end
                     end else begin
                        memoryElement <= uncachedLoad; // RULE_05 RULE_04
                     end
                  end
               end
               `OP_PREFETCH: begin
                  // Only warms the cache; no visible register changes
                  if (!mapFault) begin
                     cacheValid[elemIdx] <= 1'b1; // RULE_09
                     cacheData[elemIdx] <= elemOld;
                  end
               end
               `OP_SYNC: begin
                  // Single-ported core: all earlier accesses already complete
                  syncType <= wDataHold[`CMD_ARG_HI:`CMD_ARG_LO]; // RULE_10
                  syncStrobe <= 1'b1; // RULE_10
                  setEvents[`ST_SYNC] <= 1'b1;
               end
               `OP_COPOP: begin
                  // Arg is eight bits; upper function bits read zero
                  copFunction <= {17'h0, wDataHold[`CMD_ARG_HI:`CMD_ARG_LO]}; // RULE_13
                  copUnit <= wDataHold[`CMD_UNIT_HI:`CMD_UNIT_LO]; // RULE_13
                  copStrobe <= 1'b1;
                  setEvents[`ST_COP] <= 1'b1;
               end
               default: setEvents[`ST_EXC] <= 1'b1;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Sticky status, mask, interrupt
   // ----------------------------------------
   always @(posedge mclk) begin
      if (reset) begin
         status <= 5'h00;
         irq <= 1'b0;
      end else begin
         // Set wins over write-one-to-clear
         if (doWrite && wStrbHold != 4'h0 && awAddrHold == `REG_STATUS) begin
            status <= (status & ~wDataHold[4:0]) | setEvents;
         end else begin
            status <= status | setEvents;
         end
         // One cycle behind status; fine for a level line
         irq <= |(status & mask);
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   always @(posedge mclk) begin
      if (reset) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `RESP_OKAY;
      end else begin
         // Answer always follows one cycle after the address
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= `RESP_OKAY;
            case (araddr)
               `REG_CTRL:    rdata <= {29'h0, ctrl};
               `REG_STATUS:  rdata <= {27'h0, status};
               `REG_MASK:    rdata <= {27'h0, mask};
               `REG_VIRTUAL_ADDRESS:   rdata <= virtualAddress;
               `REG_WDATALO: rdata <= storeData[31:0];
               `REG_WDATAHI: rdata <= storeData[63:32];
               `REG_CMD:     rdata <= 32'h00000000;
               `REG_RDATALO: rdata <= memoryElement[31:0];
               `REG_RDATAHI: rdata <= memoryElement[63:32];
               `REG_PADDR:   rdata <= physAddr;
               `REG_LANES:   rdata <= {22'h0, cacheAttribute, laneReg};
               `REG_COPFUN:  rdata <= {5'h0, copUnit, copFunction};
               `REG_MEMADDR: rdata <= {24'h0, memAddrSel};
               `REG_MEMLO:   rdata <= mem[memAddrSel[`MEM_AW-1:0]][31:0];
               `REG_MEMHI:   rdata <= mem[memAddrSel[`MEM_AW-1:0]][63:32];
               default: begin
                  rdata <= 32'h00000000;
                  rresp <= `RESP_SLVERR;
               end
            endcase
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end
endmodule // load_store_access_unit

// >>> hdl/lsu_defines.vh
// Constants for the load/store access unit
`ifndef LSU_DEFINES_VH
`define LSU_DEFINES_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_MASK      8'h08
`define REG_VIRTUAL_ADDRESS     8'h0c
`define REG_WDATALO   8'h10
`define REG_WDATAHI   8'h14
`define REG_CMD       8'h18
`define REG_RDATALO   8'h1c
`define REG_RDATAHI   8'h20
`define REG_PADDR     8'h24
`define REG_LANES     8'h28
`define REG_COPFUN    8'h2c
`define REG_MEMADDR   8'h30
`define REG_MEMLO     8'h34
`define REG_MEMHI     8'h38
// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_BIGEND   0
`define CTRL_WIDE64   1
`define CTRL_MAPEN    2
// ----------------------------------------
// Command field layout
// ----------------------------------------
`define CMD_OP_LO     0
`define CMD_OP_HI     2
`define CMD_SIZE_LO   4
`define CMD_SIZE_HI   6
`define CMD_CACHED    7
`define CMD_FETCH     8
`define CMD_ARG_LO    16
`define CMD_ARG_HI    23
`define CMD_UNIT_LO   24
`define CMD_UNIT_HI   25
// ----------------------------------------
// Operations
// ----------------------------------------
`define OP_LOAD       3'h0
`define OP_STORE      3'h1
`define OP_PREFETCH   3'h2
`define OP_SYNC       3'h3
`define OP_COPOP      3'h4
// ----------------------------------------
// Status bits
// ----------------------------------------
`define ST_DONE       0
`define ST_EXC        1
`define ST_SYNC       2
`define ST_COP        3
`define ST_W          4
// ----------------------------------------
// Address map and cache block
// ----------------------------------------
`define UNMAPPED_BIT  31
`define MEM_WORDS     16
`define MEM_AW        4
`define LINE_ELEMS    2'h2
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// >>> hdl/lane_select.v
// Byte-lane selection for one access
`include "lsu_defines.vh"
module lane_select (
   input  wire [2:0] accessSizeCode,
   input  wire [2:0] lowAddr,
   input  wire       bigEndian,
   input  wire       wide64,
   output reg  [7:0] laneEnable,
   output reg        misfit
);
   // ----------------------------------------
   // Contiguous lane mask
   // ----------------------------------------
   reg [3:0] first;
   reg [3:0] last;
   reg [3:0] top;
   integer   i;
   always @* begin
      top = wide64 ? 4'h7 : 4'h3;
      first = wide64 ? {1'b0, lowAddr} : {2'b00, lowAddr[1:0]};
      if (bigEndian) begin
         first = top - first - {1'b0, accessSizeCode}; // RULE_14 RULE_01
      end
      last = first + {1'b0, accessSizeCode}; // RULE_02
      misfit = (last > top) || (first > top);
      laneEnable = 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
         if (!misfit && i[3:0] >= first && i[3:0] <= last) begin
            laneEnable[i] = 1'b1; // RULE_03
         end
      end
   end
endmodule // lane_select

// >>> dv/lsu_monitor.sv
// Port assertions for the load/store access unit
`include "lsu_defines.vh"
module lsu_monitor (
   input wire        mclk,
   input wire        reset,
   input wire        awready,
   input wire        wready,
   input wire        bvalid,
   input wire        bready,
   input wire        arvalid,
   input wire        arready,
   input wire [31:0] rdata,
   input wire [1:0]  rresp,
   input wire        rvalid,
   input wire        rready,
   input wire [24:0] copFunction,
   input wire        copStrobe,
   input wire        syncStrobe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Bus and strobe properties
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   property p_b_hold; bvalid && !bready |=> bvalid; endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
   property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer changed early");
   property p_r_answer; arvalid && arready |=> rvalid; endproperty
   a_r_answer: assert property (p_r_answer) else $error("read answer late");
   property p_w_block; bvalid |-> !awready && !wready; endproperty
   a_w_block: assert property (p_w_block) else $error("write taken while busy");
   property p_w_free; bvalid && bready |=> awready && wready; endproperty
   a_w_free: assert property (p_w_free) else $error("write port not freed");
   property p_refuse; rvalid && rresp == `RESP_SLVERR |-> rdata == 32'h0; endproperty
   a_refuse: assert property (p_refuse) else $error("refused read not zero");
   property p_cop_pulse; copStrobe |=> !copStrobe; endproperty
   a_cop_pulse: assert property (p_cop_pulse) else $error("cop strobe too long");
   property p_cop_fun; copStrobe |-> copFunction[24:8] == 17'h0; endproperty
   a_cop_fun: assert property (p_cop_fun) else $error("function field altered");
   property p_sync_pulse; syncStrobe ##1 !syncStrobe |-> !$past(syncStrobe, 2); endproperty
   a_sync_pulse: assert property (p_sync_pulse) else $error("sync strobe too long");
   c_cop: cover property (copStrobe);
   c_sync: cover property (syncStrobe);
   c_refuse: cover property (rvalid && rresp == `RESP_SLVERR);
endmodule // lsu_monitor

bind load_store_access_unit lsu_monitor u_lsu_monitor (.*);

// >>> dv/coproc_model.sv
// Coprocessor and sync listener at the far side of the unit
module coproc_model (
   input wire        mclk,
   input wire        reset,
   input wire [24:0] copFunction,
   input wire [1:0]  copUnit,
   input wire        copStrobe,
   input wire [7:0]  syncType,
   input wire        syncStrobe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [24:0] lastFunction;
   logic [1:0]  lastUnit;
   logic [7:0]  lastSync;
   int          copCount;
   int          syncCount;
   logic [63:0] copRegs [0:31];
   // Word and doubleword moves; the exact action is unit-specific
   function automatic void take_load(input logic [4:0]  coprocRegisterIndex,
                                     input logic [63:0] value,
                                     input logic        dbl);
      copRegs[coprocRegisterIndex] = dbl ? value : {32'h0, value[31:0]};
   endfunction
   function automatic logic [63:0] give_store(input logic [4:0] coprocRegisterIndex,
                                              input logic       dbl);
      return dbl ? copRegs[coprocRegisterIndex]
                 : {32'h0, copRegs[coprocRegisterIndex][31:0]};
   endfunction
   // Levels are taken only on the strobe, so stale values never count
   always @(posedge mclk) begin
      if (reset) begin
         copCount <= 0;
         syncCount <= 0;
      end else begin
         if (copStrobe) begin
            lastFunction <= copFunction;
            lastUnit <= copUnit;
            copCount <= copCount + 1;
         end
         if (syncStrobe) begin
            lastSync <= syncType;
            syncCount <= syncCount + 1;
         end
      end
   end
endmodule // coproc_model

// >>> dv/load_store_access_unit_tb.sv
// Self-checking bench for the load/store access unit
`include "lsu_defines.vh"
module load_store_access_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, reset = 1'b1, slow = 1'b0;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, got, st;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp, copUnit;
   logic awvalid, awready, wvalid, wready, bvalid, bready, ir;
   logic arvalid, arready, rvalid, rready, copStrobe, syncStrobe, irq;
   logic [24:0] copFunction;
   logic [7:0] syncType;
   int errTotal = 0, checksDone = 0, cycles = 0;
   load_store_access_unit u_load_store_access_unit (.*);
   coproc_model u_coproc_model (.*);
   always #10 mclk = ~mclk;
   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errTotal++;
         $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      awaddr <= a; wdata <= d; wstrb <= 4'hf;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= !slow;
      do begin
         @(posedge mclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      if (!bready) begin bready <= 1'b1; @(posedge mclk); end
      bready <= 1'b0;
      resp = bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      araddr <= a; arvalid <= 1'b1; rready <= !slow;
      do begin
         @(posedge mclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      if (!rready) begin rready <= 1'b1; @(posedge mclk); end
      rready <= 1'b0;
      got = rdata;
      resp = rresp;
   endtask
   // Issues one command, waits for any of status bits 3:0 unless it is a prefetch, then clears status
   task automatic op(input logic [31:0] va, input logic [2:0] o, sz, input logic c,
                     input logic [7:0] arg, input logic [1:0] u);
      wr(`REG_VIRTUAL_ADDRESS, va);
      wr(`REG_CMD, {6'h0, u, arg, 7'h0, 1'b0, c, sz, 1'b0, o});
      // Prefetch raises no status bit, so one look is all it gets
      rd(`REG_STATUS);
      while (o != `OP_PREFETCH && got[3:0] === 4'h0) rd(`REG_STATUS);
      st = got;
      ir = irq;
      wr(`REG_STATUS, 32'h1f);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      slow = 1'b1;
      rd(`REG_CTRL); chk(got, 0);
      rd(8'h3c); chk({resp, got}, {`RESP_SLVERR, 32'h0});
      wr(8'h3c, 32'h1); chk(resp, `RESP_SLVERR);
      slow = 1'b0;
   endtask
   task automatic t_lanes();
      logic [7:0] exp;
      for (int e = 0; e < 2; e++) begin
         wr(`REG_CTRL, {30'h0, 1'b1, e[0]});
         for (int n = 0; n < 8; n++) begin
            op(32'h80000000, `OP_LOAD, n[2:0], 1'b0, 8'h0, 2'h0);
            exp = e ? 8'hff << (7 - n) : 8'hff >> (7 - n);
            chk(st[`ST_EXC], 1'b0);
            rd(`REG_LANES); chk(got[7:0], exp);
         end
      end
   endtask
   task automatic t_store_load();
      wr(`REG_CTRL, 32'h2); wr(`REG_MEMADDR, 32'h0);
      wr(`REG_MEMLO, 32'h44332211); wr(`REG_MEMHI, 32'h88776655);
      wr(`REG_WDATALO, 32'hddccbbaa); wr(`REG_WDATAHI, 32'hf0f0f0f0);
      op(32'h80000002, `OP_STORE, 3'h1, 1'b0, 8'h0, 2'h0);
      rd(`REG_LANES); chk(got[7:0], 8'h0c);
      rd(`REG_MEMLO); chk(got, 32'hddcc2211);
      rd(`REG_MEMHI); chk(got, 32'h88776655);
      op(32'h80000005, `OP_LOAD, 3'h0, 1'b0, 8'h0, 2'h0);
      rd(`REG_RDATALO); chk(got, 32'h0);
      rd(`REG_RDATAHI); chk(got, 32'h00006600);
      rd(`REG_PADDR); chk(got, 32'h00000005);
      op(32'h80000000, `OP_LOAD, 3'h7, 1'b1, 8'h0, 2'h0);
      rd(`REG_LANES); chk(got[9:0], 10'h1ff);
      rd(`REG_RDATALO); chk(got, 32'hddcc2211);
      rd(`REG_RDATAHI); chk(got, 32'h88776655);
      op(32'h80000006, `OP_LOAD, 3'h3, 1'b0, 8'h0, 2'h0);
      chk(st[`ST_EXC], 1'b1);
      wr(`REG_CTRL, 32'h3);
      op(32'h80000000, `OP_STORE, 3'h0, 1'b0, 8'h0, 2'h0);
      rd(`REG_MEMHI); chk(got, 32'hf0776655);
      op(32'h80000000, `OP_LOAD, 3'h7, 1'b1, 8'h0, 2'h0);
      rd(`REG_RDATAHI); chk(got, 32'hf0776655);
   endtask
   task automatic t_prefetch();
      logic [31:0] prev, lanes;
      rd(`REG_RDATALO); prev = got;
      rd(`REG_LANES); lanes = got;
      op(32'h80000008, `OP_PREFETCH, 3'h7, 1'b1, 8'h0, 2'h0);
      chk(st, 32'h0);
      rd(`REG_RDATALO); chk(got, prev);
      rd(`REG_LANES); chk(got, lanes);
      rd(`REG_MEMLO); chk(got, 32'hddcc2211);
   endtask
   task automatic t_translate();
      wr(`REG_CTRL, 32'h6);
      op(32'h00000000, `OP_LOAD, 3'h7, 1'b0, 8'h0, 2'h0);
      chk(st[`ST_EXC], 1'b1);
      wr(`REG_MEMADDR, 32'h80000000);
      op(32'h00000000, `OP_LOAD, 3'h7, 1'b0, 8'h0, 2'h0);
      chk(st[`ST_EXC], 1'b0);
      rd(`REG_RDATALO); chk(got, 32'hddcc2211);
   endtask
   task automatic t_cop_xfer();
      logic [63:0] dw;
      rd(`REG_RDATALO); dw[31:0] = got;
      rd(`REG_RDATAHI); dw[63:32] = got;
      u_coproc_model.take_load(5'h05, dw, 1'b1);
      u_coproc_model.take_load(5'h06, dw, 1'b0);
      chk(u_coproc_model.copRegs[5], 64'hf0776655ddcc2211);
      chk(u_coproc_model.copRegs[6], 64'h00000000ddcc2211);
      dw = u_coproc_model.give_store(5'h05, 1'b0);
      chk(dw, 64'h00000000ddcc2211);
      wr(`REG_WDATALO, dw[31:0]);
      op(32'h80000008, `OP_STORE, 3'h3, 1'b0, 8'h0, 2'h0);
      wr(`REG_MEMADDR, 32'h1);
      rd(`REG_MEMLO); chk(got, 32'hddcc2211);
   endtask
   task automatic t_cop_sync();
      for (int u = 0; u < 4; u++) begin
         op(32'h80000000, `OP_COPOP, 3'h0, 1'b0, 8'h30 + u[7:0], u[1:0]);
         chk(u_coproc_model.lastFunction, 25'h30 + u);
         chk({st[`ST_COP], u_coproc_model.lastUnit}, {1'b1, u[1:0]});
      end
      op(32'h80000000, `OP_SYNC, 3'h0, 1'b0, 8'ha5, 2'h0);
      chk({st[`ST_SYNC], u_coproc_model.lastSync}, {1'b1, 8'ha5});
      chk(u_coproc_model.syncCount, 1);
      chk(u_coproc_model.copCount, 4);
   endtask
   task automatic t_irq();
      wr(`REG_MASK, 32'h1);
      op(32'h80000000, `OP_LOAD, 3'h0, 1'b0, 8'h0, 2'h0);
      chk(ir, 1'b1);
      repeat (3) @(posedge mclk);
      chk(irq, 1'b0);
      rd(`REG_STATUS); chk(got[3:0], 4'h0);
      wr(`REG_MASK, 32'h0);
      op(32'h80000000, `OP_LOAD, 3'h0, 1'b0, 8'h0, 2'h0);
      chk(ir, 1'b0);
   endtask
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", checksDone, errTotal);
      if (errTotal == 0 && checksDone > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // Sequence and hang guard
   // ----------------------------------------
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errTotal++;
         print_verdict();
      end
   end
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      t_reset();
      t_lanes();
      t_store_load();
      t_prefetch();
      t_translate();
      t_cop_xfer();
      t_cop_sync();
      t_irq();
      print_verdict();
   end
endmodule // load_store_access_unit_tb
